// ---- logic/acirq_params.svh ----
// Register offsets, field positions, reset values and the high-pass filter shift of the accelerometer readout block.
`ifndef ACIRQ_PARAMS_SVH
`define ACIRQ_PARAMS_SVH

`define ACIRQ_ADDR_IDENTITY      8'h0F
`define ACIRQ_ADDR_IRQ_CTRL      8'h22
`define ACIRQ_ADDR_FILTER_SETTLE 8'h23
`define ACIRQ_ADDR_STATUS        8'h27
`define ACIRQ_ADDR_ACCEL_X       8'h29
`define ACIRQ_ADDR_ACCEL_Y       8'h2B
`define ACIRQ_ADDR_ACCEL_Z       8'h2D

// Arbitrary neutral identification value.
`define ACIRQ_IDENTITY_VALUE     8'h5A

`define ACIRQ_CTRL_RESET         8'h00
`define ACIRQ_CTRL_POL_BIT       7
`define ACIRQ_CTRL_DRV_BIT       6
`define ACIRQ_CTRL_SELB_MSB      5
`define ACIRQ_CTRL_SELB_LSB      3
`define ACIRQ_CTRL_SELA_MSB      2
`define ACIRQ_CTRL_SELA_LSB      0

`define ACIRQ_SEL_NONE           3'h0
`define ACIRQ_SEL_MOTION_A       3'h1
`define ACIRQ_SEL_MOTION_B       3'h2
`define ACIRQ_SEL_MOTION_AB      3'h3
`define ACIRQ_SEL_SAMPLE_READY   3'h4

`define ACIRQ_AXIS_EN_RESET      3'h7
`define ACIRQ_HP_SHIFT           3

`endif

// ---- logic/acirq_pkg.sv ----
// Types shared by the accelerometer readout block and its submodules.
package acirq_pkg;

    // Interrupt pin control fields, most significant first.
    typedef struct packed {
        logic       irqPolarityLow;
        logic       irqDriveType;
        logic [2:0] pinBSourceSel;
        logic [2:0] pinASourceSel;
    } acirq_ctrl_t;

    // Host register access port.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acirq_req_t;

    // State of the readout top.
    typedef struct packed {
        logic [2:0][7:0] axisOut;
        logic [2:0][7:0] hpDc;
        logic [2:0]      newSample;
        logic [2:0]      overrun;
        logic [2:0]      readMask;
        logic            allNewSample;
        logic            allOverrun;
        logic            allPrev;
        logic            genTick;
        acirq_ctrl_t     ctrl;
        logic [7:0]      rdata;
        logic            rdValid;
    } acirq_state_t;

    // State of one pin driver.
    typedef struct packed {
        logic pinOut;
        logic pinOe;
    } acirq_pin_state_t;

    // State of one motion generator.
    typedef struct packed {
        logic [7:0] source;
        logic       irq;
    } acirq_motion_state_t;

endpackage : acirq_pkg

// ---- logic/acirq_pin_drive.sv ----
// Interrupt pin source selection, polarity and pad drive type.
`timescale 1ns/1ps
`include "acirq_params.svh"

module acirq_pin_drive (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [2:0] sourceSel,
    input  wire logic       irqPolarityLow,
    input  wire logic       irqDriveType,
    input  wire logic       motionIrqA,
    input  wire logic       motionIrqB,
    input  wire logic       sampleReadySignal,
    output logic            pinOut,
    output logic            pinOe
);

    acirq_pkg::acirq_pin_state_t s_q;
    acirq_pkg::acirq_pin_state_t s_d;
    logic active;
    logic level;

    // Pick the source; unused codes fall back to the idle level like code zero.
    always_comb
    begin
        case (sourceSel)
            `ACIRQ_SEL_MOTION_A:     active = motionIrqA;
            `ACIRQ_SEL_MOTION_B:     active = motionIrqB;
            `ACIRQ_SEL_MOTION_AB:    active = motionIrqA | motionIrqB;
            `ACIRQ_SEL_SAMPLE_READY: active = sampleReadySignal;
            default:                 active = 1'b0;
        endcase
        level = active ^ irqPolarityLow;
        s_d   = s_q;
        // Open drain only ever pulls low, so several pads can share one line.
        if (irqDriveType)
        begin
            s_d.pinOut = 1'b0;
            s_d.pinOe  = ~level;
        end
        else
        begin
            s_d.pinOut = level;
            s_d.pinOe  = 1'b1;
        end
    end

    // Register the pad controls so the pins never glitch on selector changes.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '{pinOut: 1'b0, pinOe: 1'b1};
        else
            s_q <= s_d;
    end

    assign pinOut = s_q.pinOut;
    assign pinOe  = s_q.pinOe;

    property p_pin_idle;
        @(posedge clk) disable iff (!resetn)
        (sourceSel == `ACIRQ_SEL_NONE || sourceSel > `ACIRQ_SEL_SAMPLE_READY) && !irqDriveType
            |=> pinOut == $past(irqPolarityLow) && pinOe;
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("Idle pin level wrong");

    property p_open_drain;
        @(posedge clk) disable iff (!resetn)
        irqDriveType |=> !pinOut;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("Open drain pin drove high");

endmodule : acirq_pin_drive

// ---- logic/acirq_motion_gen.sv ----
// One motion interrupt generator: threshold compare and event source register.
`timescale 1ns/1ps

module acirq_motion_gen (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            tick,
    input  wire logic [2:0]      axisEnable,
    input  wire logic [2:0][7:0] axisData,
    input  wire logic [6:0]      threshold,
    output logic                 motionIrq,
    output logic [7:0]           motionSource
);

    acirq_pkg::acirq_motion_state_t s_q;
    acirq_pkg::acirq_motion_state_t s_d;
    logic [5:0] flags;

    // Compare each enabled axis magnitude against the threshold, low/high per axis.
    always_comb
    begin
        logic [7:0] mag;
        mag   = 8'h00;
        flags = 6'h00;
        for (int i = 0; i < 3; i++)
        begin
            mag = axisData[i][7] ? 8'(-axisData[i]) : axisData[i];
            flags[2*i+1] = axisEnable[i] & (mag >= {1'b0, threshold});
            flags[2*i]   = axisEnable[i] & (mag <  {1'b0, threshold});
        end
        s_d = s_q;
        // The generator output loads its own event source register.
        if (tick)
        begin
            s_d.irq    = |{flags[5], flags[3], flags[1]};
            s_d.source = {1'b0, s_d.irq, flags};
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign motionIrq    = s_q.irq;
    assign motionSource = s_q.source;

endmodule : acirq_motion_gen

// ---- logic/acirq_top.sv ----
// Accelerometer readout: status flags, output registers, filter settle and interrupt routing.
//
// Contract
// - Polarity bit 0 drives active interrupt high; 1 drives it low.
// - Drive-type bit selects push-pull at 0, open-drain at 1.
// - Each pin has 3-bit selector: idle, motion A, motion B, both, data-ready.
// - Two independent motion generators, either routable to either pin.
// - Each generator uses raw data, or high-passed data when its select bit is set.
// - Generator outputs load their own event source registers.
// - Identity register always reads a fixed code.
// - Combined new-sample flag sets when all enabled axes fresh, clears after all read.
// - Axis new-sample flag sets on new sample, clears on that axis read.
// - Axis new-sample flag can only set while that axis is enabled.
// - Status bits: all overrun, Z, Y, X overrun, all new, Z, Y, X new.
// - Axis outputs are 8-bit read-only registers at 29h, 2Bh, 2Dh.
// - Reading the settle location zeroes the high-pass output at once.
// - Pin control register holds polarity, drive type and two selectors, reset zero.
// - Axis enable bits, reset one, gate the new-sample indication per axis; the code takes them from the axisEnable input, with no reset of its own.
`timescale 1ns/1ps
`include "acirq_params.svh"

module acirq_top #(
    parameter logic [7:0] IDENTITY = `ACIRQ_IDENTITY_VALUE
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            regRd,
    input  wire logic            regWr,
    input  wire logic [7:0]      regAddr,
    input  wire logic [7:0]      regWdata,
    output logic [7:0]           regRdata,
    output logic                 regRdValid,
    input  wire logic [2:0]      sampleStrobe,
    input  wire logic [2:0][7:0] sampleData,
    input  wire logic [2:0]      axisEnable,
    input  wire logic            hpSelectMotionA,
    input  wire logic            hpSelectMotionB,
    input  wire logic [6:0]      motionAThreshold,
    input  wire logic [6:0]      motionBThreshold,
    output logic [7:0]           motionASource,
    output logic [7:0]           motionBSource,
    output logic                 irqPinAOut,
    output logic                 irqPinAOe,
    output logic                 irqPinBOut,
    output logic                 irqPinBOe
);

    acirq_pkg::acirq_req_t   req;
    acirq_pkg::acirq_state_t s_q;
    acirq_pkg::acirq_state_t s_d;
    logic [2:0]              axisRead;
    logic [2:0]              accepted;
    logic [2:0][7:0]         hpData;
    logic [2:0][7:0]         motionAData;
    logic [2:0][7:0]         motionBData;
    logic                    motionIrqA;
    logic                    motionIrqB;
    logic                    allFresh;
    logic                    allRead;
    logic                    settleRead;

    assign req = '{rd: regRd, wr: regWr, addr: regAddr, wdata: regWdata};

    // Decode the reads that have side effects.
    assign axisRead[0] = req.rd && req.addr == `ACIRQ_ADDR_ACCEL_X;
    assign axisRead[1] = req.rd && req.addr == `ACIRQ_ADDR_ACCEL_Y;
    assign axisRead[2] = req.rd && req.addr == `ACIRQ_ADDR_ACCEL_Z;
    assign settleRead  = req.rd && req.addr == `ACIRQ_ADDR_FILTER_SETTLE;
    assign accepted    = sampleStrobe & axisEnable;

    // High-pass output per axis, and the data each generator consumes.
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_axis
            assign hpData[g]      = 8'(s_q.axisOut[g] - s_q.hpDc[g]);
            assign motionAData[g] = hpSelectMotionA ? hpData[g] : s_q.axisOut[g];
            assign motionBData[g] = hpSelectMotionB ? hpData[g] : s_q.axisOut[g];
        end
    endgenerate

    // Next state of flags, data, filter and register file.
    always_comb
    begin
        logic [2:0] readNext;
        readNext  = 3'h0;
        s_d       = s_q;
        s_d.genTick = |accepted;
        // Per-axis flags: a new sample in the same cycle as a read wins.
        for (int i = 0; i < 3; i++)
        begin
            if (axisRead[i])
            begin
                s_d.newSample[i] = 1'b0;
                s_d.overrun[i]   = 1'b0;
            end
            if (accepted[i])
            begin
                s_d.axisOut[i]   = sampleData[i];
                s_d.overrun[i]   = s_q.newSample[i] & ~axisRead[i] | s_d.overrun[i];
                s_d.newSample[i] = 1'b1;
                // Leaky dc tracker; the shift trades settling speed for ripple.
                s_d.hpDc[i] = 8'(s_q.hpDc[i] + 8'($signed(8'(sampleData[i] - s_q.hpDc[i])) >>> `ACIRQ_HP_SHIFT));
            end
            else if (settleRead)
            begin
                s_d.hpDc[i] = s_q.axisOut[i];
            end
        end
        // Read tracking restarts with every accepted sample on any axis.
        readNext = (|accepted) ? axisRead & ~accepted : s_q.readMask | axisRead;
        s_d.readMask = readNext;
        allRead  = (|axisRead) && (&((s_q.readMask | axisRead) | ~axisEnable));
        allFresh = (|axisEnable) && (&(s_d.newSample | ~axisEnable));
        s_d.allPrev = allFresh;
        if (allRead)
        begin
            s_d.allNewSample = 1'b0;
            s_d.allOverrun   = 1'b0;
        end
        if (allFresh && !s_q.allPrev)
            s_d.allNewSample = 1'b1;
        if (|(accepted & s_q.newSample & ~axisRead))
            s_d.allOverrun = 1'b1;
        // Register write port; only the pin control register is writable.
        if (req.wr && req.addr == `ACIRQ_ADDR_IRQ_CTRL)
            s_d.ctrl = acirq_pkg::acirq_ctrl_t'(req.wdata);
        // Read data is returned one cycle after the read strobe.
        s_d.rdValid = req.rd;
        s_d.rdata   = 8'h00;
        if (req.rd)
        begin
            case (req.addr)
                `ACIRQ_ADDR_IDENTITY: s_d.rdata = IDENTITY;
                `ACIRQ_ADDR_IRQ_CTRL: s_d.rdata = s_q.ctrl;
                `ACIRQ_ADDR_STATUS:   s_d.rdata = {s_q.allOverrun, s_q.overrun[2], s_q.overrun[1],
                                                   s_q.overrun[0], s_q.allNewSample, s_q.newSample[2],
                                                   s_q.newSample[1], s_q.newSample[0]};
                `ACIRQ_ADDR_ACCEL_X:  s_d.rdata = s_q.axisOut[0];
                `ACIRQ_ADDR_ACCEL_Y:  s_d.rdata = s_q.axisOut[1];
                `ACIRQ_ADDR_ACCEL_Z:  s_d.rdata = s_q.axisOut[2];
                default:              s_d.rdata = 8'h00;
            endcase
        end
    end

    // Single register stage for the whole readout state.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q      <= '0;
            s_q.ctrl <= `ACIRQ_CTRL_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign regRdata   = s_q.rdata;
    assign regRdValid = s_q.rdValid;

    // Two independent generators, each fed by its own data path.
    acirq_motion_gen u_motion_a (
        .clk          (clk),
        .resetn       (resetn),
        .tick         (s_q.genTick),
        .axisEnable   (axisEnable),
        .axisData     (motionAData),
        .threshold    (motionAThreshold),
        .motionIrq    (motionIrqA),
        .motionSource (motionASource)
    );

    acirq_motion_gen u_motion_b (
        .clk          (clk),
        .resetn       (resetn),
        .tick         (s_q.genTick),
        .axisEnable   (axisEnable),
        .axisData     (motionBData),
        .threshold    (motionBThreshold),
        .motionIrq    (motionIrqB),
        .motionSource (motionBSource)
    );

    // Both pins share polarity and drive type but select independently.
    acirq_pin_drive u_pin_a (
        .clk               (clk),
        .resetn            (resetn),
        .sourceSel         (s_q.ctrl.pinASourceSel),
        .irqPolarityLow    (s_q.ctrl.irqPolarityLow),
        .irqDriveType      (s_q.ctrl.irqDriveType),
        .motionIrqA        (motionIrqA),
        .motionIrqB        (motionIrqB),
        .sampleReadySignal (s_q.allNewSample),
        .pinOut            (irqPinAOut),
        .pinOe             (irqPinAOe)
    );

    acirq_pin_drive u_pin_b (
        .clk               (clk),
        .resetn            (resetn),
        .sourceSel         (s_q.ctrl.pinBSourceSel),
        .irqPolarityLow    (s_q.ctrl.irqPolarityLow),
        .irqDriveType      (s_q.ctrl.irqDriveType),
        .motionIrqA        (motionIrqA),
        .motionIrqB        (motionIrqB),
        .sampleReadySignal (s_q.allNewSample),
        .pinOut            (irqPinBOut),
        .pinOe             (irqPinBOe)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_new_sample_set;
        sampleStrobe[0] && axisEnable[0] |=> s_q.newSample[0];
    endproperty
    a_new_sample_set: assert property (p_new_sample_set) else $error("X new flag not set");

    property p_disabled_no_set;
        !sampleStrobe[2] ##1 sampleStrobe[2] && !axisEnable[2] && !s_q.newSample[2] |=> !s_q.newSample[2];
    endproperty
    a_disabled_no_set: assert property (p_disabled_no_set) else $error("Disabled Z set flag");

    // A strobe on a disabled axis must not even store its data.
    property p_disabled_hold;
        sampleStrobe[2] && !axisEnable[2] |=> s_q.axisOut[2] == $past(s_q.axisOut[2]);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("Disabled Z stored data");

    property p_overrun_clear;
        axisRead[2] && !sampleStrobe[2] |=> !s_q.overrun[2] && !s_q.newSample[2];
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) else $error("Z flags not cleared");

    property p_overrun_set;
        accepted[0] && s_q.newSample[0] && !axisRead[0] |=> s_q.overrun[0] && s_q.allOverrun;
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("Overrun not set");

    property p_identity;
        regRd && regAddr == `ACIRQ_ADDR_IDENTITY |=> regRdValid && regRdata == IDENTITY;
    endproperty
    a_identity: assert property (p_identity) else $error("Identity read wrong");

    property p_status_layout;
        regRd && regAddr == `ACIRQ_ADDR_STATUS |=>
            regRdata == {$past(s_q.allOverrun), $past(s_q.overrun), $past(s_q.allNewSample), $past(s_q.newSample)};
    endproperty
    a_status_layout: assert property (p_status_layout) else $error("Status layout wrong");

    property p_settle;
        settleRead && sampleStrobe == 3'h0 |=> hpData[0] == 8'h00 && hpData[1] == 8'h00 && hpData[2] == 8'h00;
    endproperty
    a_settle: assert property (p_settle) else $error("Filter not settled");

    // The host leaves one idle cycle between strobes, so the readback follows after a gap.
    property p_ctrl_write;
        regWr && regAddr == `ACIRQ_ADDR_IRQ_CTRL ##1 !regWr ##1 regRd && regAddr == `ACIRQ_ADDR_IRQ_CTRL
            |=> regRdata == $past(regWdata, 3);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("Control readback wrong");

    property p_all_new_clear;
        s_q.allNewSample && allRead && sampleStrobe == 3'h0 |=> !s_q.allNewSample;
    endproperty
    a_all_new_clear: assert property (p_all_new_clear) else $error("All-new flag not cleared");

    // An axis output read returns the value held in the cycle of the strobe.
    property p_axis_readout;
        regRd && regAddr == `ACIRQ_ADDR_ACCEL_Y |=> regRdValid && regRdata == $past(s_q.axisOut[1]);
    endproperty
    a_axis_readout: assert property (p_axis_readout) else $error("Y output read wrong");

    c_settle: cover property (settleRead ##1 hpData[0] == 8'h00);

    c_all_new: cover property (s_q.allNewSample ##[1:20] !s_q.allNewSample);
    c_overrun: cover property (s_q.allOverrun);
    c_pin_motion: cover property (s_q.ctrl.pinASourceSel == `ACIRQ_SEL_MOTION_A && motionIrqA);

endmodule : acirq_top

// ---- dv/acirq_host_model.sv ----
// Host processor model that reaches the readout registers with one-cycle strobes.
`timescale 1ns/1ps

module acirq_host_model (
    input  wire logic       clk,
    output logic            regRd,
    output logic            regWr,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWdata,
    input  wire logic [7:0] regRdata,
    input  wire logic       regRdValid
);
    // Quiet bus at time zero.
    initial
    begin
        regRd    = 1'b0;
        regWr    = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end

    // A write is one strobe; released lines show the inverse so stale values never look current.
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        regWr    = 1'b1;
        regAddr  = addr;
        regWdata = data;
        @(negedge clk);
        regWr    = 1'b0;
        regAddr  = ~addr;
        regWdata = ~data;
    endtask : wr_reg

    // The answer is registered, so it stands in the cycle after the strobe edge.
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(negedge clk);
        regRd   = 1'b1;
        regAddr = addr;
        @(negedge clk);
        regRd   = 1'b0;
        regAddr = ~addr;
        ok      = regRdValid;
        data    = regRdata;
    endtask : rd_reg
endmodule : acirq_host_model

// ---- dv/tb.sv ----
// Self-checking testbench of the accelerometer readout block.
`timescale 1ns/1ps

module tb;
    logic            clk, resetn, regRd, regWr, regRdValid, hpSelectMotionA, hpSelectMotionB;
    logic [7:0]      regAddr, regWdata, regRdata, motionASource, motionBSource;
    logic [2:0]      sampleStrobe, axisEnable;
    logic [2:0][7:0] sampleData;
    logic            irqPinAOut, irqPinAOe, irqPinBOut, irqPinBOe;
    int              err_total = 0;
    int              num_checks = 0;

    acirq_top #(.IDENTITY(8'hC3)) u_dut (.clk(clk), .resetn(resetn), .regRd(regRd), .regWr(regWr),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
        .sampleStrobe(sampleStrobe), .sampleData(sampleData), .axisEnable(axisEnable),
        .hpSelectMotionA(hpSelectMotionA), .hpSelectMotionB(hpSelectMotionB),
        .motionAThreshold(7'h0A), .motionBThreshold(7'h7F), .motionASource(motionASource),
        .motionBSource(motionBSource), .irqPinAOut(irqPinAOut), .irqPinAOe(irqPinAOe),
        .irqPinBOut(irqPinBOut), .irqPinBOe(irqPinBOe));

    acirq_host_model u_host (.clk(clk), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid));

    // Free-running 40 MHz clock.
    always #12.5 clk = ~clk;

    task automatic give_verdict;
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host.rd_reg(addr, d, ok);
        check({7'h00, ok}, 8'h01, "read answer");
        check(d, exp, "read data");
    endtask : rd_chk

    // Strobe held for one edge; the data bus then shows a different pattern.
    task automatic strobe(input logic [2:0] m, input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
        @(negedge clk);
        sampleStrobe = m;
        sampleData   = {z, y, x};
        @(negedge clk);
        sampleStrobe = 3'h0;
        sampleData   = ~{z, y, x};
    endtask : strobe

    // Expected pad pair {out, oe}; open drain only ever pulls low.
    function automatic logic [1:0] pad(input logic act, input logic pol, input logic od);
        return od ? {1'b0, ~(act ^ pol)} : {act ^ pol, 1'b1};
    endfunction : pad

    // Motion A active, motion B quiet and an unread full set pending.
    function automatic logic route(input logic [2:0] c);
        return (c == 3'h1) || (c == 3'h3) || (c == 3'h4);
    endfunction : route

    task automatic t_reset;
        check({6'h00, irqPinAOut, irqPinAOe}, 8'h01, "idle pin a");
        rd_chk(8'h0F, 8'hC3);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h27, 8'h00);
        rd_chk(8'h2A, 8'h00);
    endtask : t_reset

    task automatic t_ctrl;
        u_host.wr_reg(8'h27, 8'hFF);
        u_host.wr_reg(8'h0F, 8'h00);
        u_host.wr_reg(8'h22, 8'hC9);
        rd_chk(8'h22, 8'hC9);
        rd_chk(8'h27, 8'h00);
        rd_chk(8'h0F, 8'hC3);
        u_host.wr_reg(8'h22, 8'h00);
    endtask : t_ctrl

    task automatic t_flags;
        strobe(3'h7, 8'h11, 8'h22, 8'h33);
        rd_chk(8'h27, 8'h0F);
        rd_chk(8'h29, 8'h11);
        rd_chk(8'h27, 8'h0E);
        rd_chk(8'h2B, 8'h22);
        rd_chk(8'h2D, 8'h33);
        rd_chk(8'h27, 8'h00);
        strobe(3'h7, 8'h44, 8'h55, 8'h66);
        strobe(3'h7, 8'h77, 8'h88, 8'h99);
        rd_chk(8'h27, 8'hFF);
        rd_chk(8'h29, 8'h77);
        rd_chk(8'h27, 8'hEE);
        rd_chk(8'h2B, 8'h88);
        rd_chk(8'h2D, 8'h99);
        rd_chk(8'h27, 8'h00);
    endtask : t_flags

    task automatic t_enable;
        axisEnable = 3'h3;
        strobe(3'h7, 8'h01, 8'h02, 8'h03);
        rd_chk(8'h27, 8'h0B);
        rd_chk(8'h2D, 8'h99);
        rd_chk(8'h29, 8'h01);
        rd_chk(8'h2B, 8'h02);
        rd_chk(8'h27, 8'h00);
        axisEnable = 3'h7;
    endtask : t_enable

    task automatic t_pins;
        logic [4:0] v;
        strobe(3'h7, 8'h14, 8'h00, 8'h00);
        repeat (3) @(negedge clk);
        check(motionASource, 8'h56, "source a");
        check(motionBSource, 8'h15, "source b");
        for (int m = 0; m < 32; m++)
        begin
            v = 5'(m);
            u_host.wr_reg(8'h22, {v[4], v[3], v[2:0] ^ 3'h3, v[2:0]});
            repeat (2) @(negedge clk);
            check({6'h00, irqPinAOut, irqPinAOe}, {6'h00, pad(route(v[2:0]), v[4], v[3])}, "pin a");
            check({6'h00, irqPinBOut, irqPinBOe}, {6'h00, pad(route(v[2:0] ^ 3'h3), v[4], v[3])}, "pin b");
        end
    endtask : t_pins

    task automatic t_settle;
        logic [7:0] d;
        logic       ok;
        hpSelectMotionA = 1'b1;
        hpSelectMotionB = 1'b1;
        u_host.rd_reg(8'h23, d, ok);
        strobe(3'h7, 8'h14, 8'h00, 8'h00);
        repeat (3) @(negedge clk);
        check(motionASource, 8'h15, "settled a");
        check(motionBSource, 8'h15, "settled b");
        hpSelectMotionA = 1'b0;
        strobe(3'h7, 8'h14, 8'h00, 8'h00);
        repeat (3) @(negedge clk);
        check(motionASource, 8'h56, "raw a");
    endtask : t_settle

    // Main sequence: inputs set at time zero, reset held 20 cycles, then the scenarios.
    initial
    begin
        clk             = 1'b0;
        resetn          = 1'b0;
        sampleStrobe    = 3'h0;
        sampleData      = '0;
        axisEnable      = 3'h7;
        hpSelectMotionA = 1'b0;
        hpSelectMotionB = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        t_reset();
        t_ctrl();
        t_flags();
        t_enable();
        t_pins();
        t_settle();
        give_verdict();
    end

    // Watchdog: the scenarios need well under a thousand cycles.
    initial
    begin
        #(25 * 4000);
        err_total++;
        give_verdict();
    end
endmodule : tb
